// ---- core/adc_status_readout.sv ----
`timescale 1ns/1ps
// Functional notes
// - Low-threshold flag sets on event, resets zero, write one clears.
// - Analog reset flag resets one, set by supply drop or soft reset.
// - Conversion timing error sets on short period, resets zero, W1C.
// - ROM integrity flag is read-only, one after a CRC/ECC fault.
// - Logic reset flag resets one, set by logic drop or soft reset.
// - Fixed-pattern enable sends constant test word on LVDS only.
// - Lane select: one lane, else two LVDS or four SPI lanes.
// - Port select one routes data to SPI and powers LVDS down.
// - SPI readout clocked by host read clock, framed by select.
// - Status register at 0x14 resets to 0x09.
module adc_status_readout (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // Register port
   input wire adc_cfg_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Device events
   input wire adc_cfg_pkg::events_t events,
   // Conversion results
   input wire logic [adc_cfg_pkg::WORD_W-1:0] conv_word,
   input wire logic conv_valid,
   // LVDS side
   output logic [adc_cfg_pkg::WORD_W-1:0] lvds_word,
   output logic lvds_word_valid,
   output logic lvds_power_down,
   output logic [2:0] active_lanes,
   // SPI data readout link
   input wire logic fifo_read_clock,
   input wire logic fifo_read_select_n,
   output logic [3:0] spi_data_out
);

   // ==========================================================
   // Decoding
   function automatic logic hits(input adc_cfg_pkg::reg_req_t r,
                                 input logic [7:0] a);
      hits = r.addr == a;
   endfunction

   function automatic logic [2:0] lanes_of(input adc_cfg_pkg::cfg_t c);
      if (!c.lane_count_select) begin
         lanes_of = adc_cfg_pkg::LANES_ONE;
      end else if (c.readout_port_select) begin
         lanes_of = adc_cfg_pkg::LANES_FOUR;
      end else begin
         lanes_of = adc_cfg_pkg::LANES_TWO;
      end
   endfunction

   localparam adc_cfg_pkg::sys_state_t RESET_STATE = '{
      st: adc_cfg_pkg::STATUS_RESET[4:0],
      cfg: adc_cfg_pkg::CFG_RESET,
      default: '0};

   adc_cfg_pkg::sys_state_t s_r;
   adc_cfg_pkg::sys_state_t s_nxt;
   adc_cfg_pkg::status_t set_v;
   logic [4:0] clr_v;
   logic ack_toggle;
   logic busy;
   logic wr_status;

   assign wr_status = reg_req.wr && hits(reg_req, adc_cfg_pkg::STATUS_ADDR);
   assign busy = s_r.req != s_r.ack_sync[1];

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      set_v.low_threshold_flag = events.low_threshold;
      set_v.analog_power_on_reset_flag = events.analog_supply_drop
                                         | events.soft_reset;
      set_v.conversion_timing_error_flag = events.conv_period_violation;
      // ROM fault is sticky until reset
      set_v.rom_integrity_flag = events.rom_fault;
      set_v.logic_power_on_reset_flag = events.logic_supply_drop
                                        | events.soft_reset;
      clr_v = wr_status ? (reg_req.wdata[4:0] & adc_cfg_pkg::W1C_MASK)
                        : 5'h00;
      s_nxt.st = (s_r.st & ~clr_v) | set_v;

      // Only bits 6, 4, 2, 0 take writes; others stay read-only
      if (reg_req.wr && hits(reg_req, adc_cfg_pkg::CFG_ADDR)) begin
         s_nxt.cfg = (s_r.cfg & ~adc_cfg_pkg::CFG_WMASK)
                   | (reg_req.wdata & adc_cfg_pkg::CFG_WMASK);
      end
      if (events.soft_reset) begin
         s_nxt.cfg = adc_cfg_pkg::CFG_RESET;
      end

      // Status read back at its address
      if (reg_req.rd) begin
         if (hits(reg_req, adc_cfg_pkg::STATUS_ADDR)) begin
            s_nxt.rdata = {3'h0, s_r.st};
         end else if (hits(reg_req, adc_cfg_pkg::CFG_ADDR)) begin
            s_nxt.rdata = s_r.cfg;
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end

      s_nxt.ack_sync = {s_r.ack_sync[0], ack_toggle};
      s_nxt.lvds_valid = 1'b0;
      if (conv_valid) begin
         if (!s_r.cfg.readout_port_select) begin
            s_nxt.lvds_valid = 1'b1;
            s_nxt.lvds_word = s_r.cfg.fixed_pattern_enable
                            ? adc_cfg_pkg::TEST_PATTERN : conv_word;
         end else if (!busy) begin
            // No buffering: a word arriving while busy is dropped
            s_nxt.spi_word = conv_word;
            s_nxt.req = ~s_r.req;
         end
      end
      // LVDS powered down in SPI mode
      s_nxt.lvds_pd = s_r.cfg.readout_port_select;
      s_nxt.lanes = lanes_of(s_r.cfg);
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s_r <= RESET_STATE;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Readout link on the host read clock
   spi_readout_link u_link (
      .fifo_read_clock(fifo_read_clock),
      .fifo_read_select_n(fifo_read_select_n),
      .reset_n(reset_n),
      .word_in(s_r.spi_word),
      .req_toggle(s_r.req),
      .four_lanes(s_r.cfg.lane_count_select),
      .ack_toggle(ack_toggle),
      .data_out(spi_data_out)
   );

   assign reg_rdata = s_r.rdata;
   assign lvds_word = s_r.lvds_word;
   assign lvds_word_valid = s_r.lvds_valid;
   assign lvds_power_down = s_r.lvds_pd;
   assign active_lanes = s_r.lanes;

   // ==========================================================
   // Checks
   a_lo_sets: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && events.low_threshold |=> s_r.st.low_threshold_flag)
      else $error("low-threshold flag not set");

   a_lo_clears: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && wr_status && reg_req.wdata[4] && !events.low_threshold
      |=> !s_r.st.low_threshold_flag)
      else $error("low-threshold flag not cleared");

   a_ana_por_sets: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && (events.analog_supply_drop || events.soft_reset)
      |=> s_r.st.analog_power_on_reset_flag)
      else $error("analog reset flag not set");

   a_cnv_err_sets: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && events.conv_period_violation
      |=> s_r.st.conversion_timing_error_flag)
      else $error("conversion error flag not set");

   a_rom_sticky: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      s_r.st.rom_integrity_flag |=> s_r.st.rom_integrity_flag)
      else $error("ROM flag cleared without reset");

   a_por_sets: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && (events.logic_supply_drop || events.soft_reset)
      |=> s_r.st.logic_power_on_reset_flag)
      else $error("logic reset flag not set");

   a_pattern_out: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && conv_valid && !s_r.cfg.readout_port_select
      && s_r.cfg.fixed_pattern_enable
      |=> lvds_word_valid && lvds_word == adc_cfg_pkg::TEST_PATTERN)
      else $error("test pattern not sent");

   a_lane_count: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en |=> active_lanes == lanes_of($past(s_r.cfg)))
      else $error("wrong active lane count");

   a_spi_no_lvds: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && s_r.cfg.readout_port_select
      |=> !lvds_word_valid && lvds_power_down)
      else $error("LVDS active in SPI mode");

   a_status_reset: assert property (
      @(posedge clk_sys)
      $rose(reset_n) |-> {3'h0, s_r.st} == adc_cfg_pkg::STATUS_RESET)
      else $error("status reset value wrong");

   a_w1c_zero: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && wr_status && reg_req.wdata == 8'h00
      |=> (s_r.st & $past(s_r.st)) == $past(s_r.st))
      else $error("flag lost on zero write");

   c_lo_cycle: cover property (@(posedge clk_sys) disable iff (!reset_n)
      s_r.st.low_threshold_flag ##[1:20] !s_r.st.low_threshold_flag);
   c_spi_handoff: cover property (@(posedge clk_sys) disable iff (!reset_n)
      busy ##[1:200] !busy);
   c_pattern: cover property (@(posedge clk_sys) disable iff (!reset_n)
      lvds_word_valid && lvds_word == adc_cfg_pkg::TEST_PATTERN);

endmodule // adc_status_readout

// ---- core/adc_cfg_pkg.sv ----
package adc_cfg_pkg;

   // ==========================================================
   // Register map and reset values
   localparam int WORD_W = 20;
   localparam logic [7:0] STATUS_ADDR = 8'h14;
   localparam logic [7:0] CFG_ADDR = 8'h15;
   localparam logic [7:0] STATUS_RESET = 8'h09;
   localparam logic [7:0] CFG_RESET = 8'h40;
   localparam logic [7:0] CFG_WMASK = 8'h55;
   localparam logic [4:0] W1C_MASK = 5'h1d;
   localparam logic [19:0] TEST_PATTERN = 20'hac5d6;

   // ==========================================================
   // Lane counts and shift lengths
   localparam logic [2:0] LANES_ONE = 3'h1;
   localparam logic [2:0] LANES_TWO = 3'h2;
   localparam logic [2:0] LANES_FOUR = 3'h4;
   localparam logic [4:0] SHIFTS_ONE_LANE = 5'h14;
   localparam logic [4:0] SHIFTS_FOUR_LANE = 5'h05;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic low_threshold_flag;
      logic analog_power_on_reset_flag;
      logic conversion_timing_error_flag;
      logic rom_integrity_flag;
      logic logic_power_on_reset_flag;
   } status_t;

   typedef struct packed {
      logic rsvd7;
      logic fixed_one;
      logic rsvd5;
      logic fixed_pattern_enable;
      logic rsvd3;
      logic lane_count_select;
      logic rsvd1;
      logic readout_port_select;
   } cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic low_threshold;
      logic analog_supply_drop;
      logic logic_supply_drop;
      logic soft_reset;
      logic conv_period_violation;
      logic rom_fault;
   } events_t;

   typedef struct packed {
      status_t st;
      cfg_t cfg;
      logic [7:0] rdata;
      logic [WORD_W-1:0] lvds_word;
      logic lvds_valid;
      logic lvds_pd;
      logic [2:0] lanes;
      logic [WORD_W-1:0] spi_word;
      logic req;
      logic [1:0] ack_sync;
   } sys_state_t;

   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] req_sync;
      logic [1:0] lane_sync;
      logic ack;
   } link_keep_t;

   typedef struct packed {
      logic loaded;
      logic [4:0] cnt;
      logic [WORD_W-1:0] sr;
      logic [3:0] dout;
   } link_frame_t;

endpackage

// ---- core/spi_readout_link.sv ----
`timescale 1ns/1ps
module spi_readout_link (
   // Link clock and frame
   input wire logic fifo_read_clock,
   input wire logic fifo_read_select_n,
   // From system domain
   input wire logic reset_n,
   input wire logic [adc_cfg_pkg::WORD_W-1:0] word_in,
   input wire logic req_toggle,
   input wire logic four_lanes,
   // To system domain and pins
   output logic ack_toggle,
   output logic [3:0] data_out
);

   adc_cfg_pkg::link_keep_t k_r;
   adc_cfg_pkg::link_keep_t k_nxt;
   adc_cfg_pkg::link_frame_t f_r;
   adc_cfg_pkg::link_frame_t f_nxt;
   logic pending;
   logic four;
   logic [4:0] limit;

   assign pending = k_r.req_sync[1] != k_r.ack;
   assign four = k_r.lane_sync[1];
   assign limit = four ? adc_cfg_pkg::SHIFTS_FOUR_LANE
                       : adc_cfg_pkg::SHIFTS_ONE_LANE;

   // ==========================================================
   // Persistent crossing state
   always_comb begin
      k_nxt = k_r;
      k_nxt.rst_sync = {k_r.rst_sync[0], reset_n};
      k_nxt.req_sync = {k_r.req_sync[0], req_toggle};
      k_nxt.lane_sync = {k_r.lane_sync[0], four_lanes};
      if (!k_r.rst_sync[1]) begin
         k_nxt.ack = 1'b0;
      end else if (!f_r.loaded && pending) begin
         k_nxt.ack = ~k_r.ack;
      end
   end

   always_ff @(posedge fifo_read_clock) begin
      k_r <= k_nxt;
   end

   // ==========================================================
   // Frame shifter, cleared by the select going high
   always_comb begin
      f_nxt = f_r;
      if (!k_r.rst_sync[1]) begin
         f_nxt = '0;
      end else if (!f_r.loaded) begin
         f_nxt.loaded = 1'b1;
         f_nxt.cnt = 5'h01;
         f_nxt.sr = pending ? word_in : '0;
         f_nxt.dout = four ? f_nxt.sr[19:16] : {3'h0, f_nxt.sr[19]};
         f_nxt.sr = four ? {f_nxt.sr[15:0], 4'h0} : {f_nxt.sr[18:0], 1'b0};
      end else if (f_r.cnt < limit) begin
         f_nxt.cnt = f_r.cnt + 5'h01;
         f_nxt.dout = four ? f_r.sr[19:16] : {3'h0, f_r.sr[19]};
         f_nxt.sr = four ? {f_r.sr[15:0], 4'h0} : {f_r.sr[18:0], 1'b0};
      end else begin
         f_nxt.dout = 4'h0;
      end
   end

   // Clock stands still between frames, so the select ends the frame
   always_ff @(posedge fifo_read_clock or posedge fifo_read_select_n) begin
      if (fifo_read_select_n) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end

   assign ack_toggle = k_r.ack;
   assign data_out = f_r.dout;

   // ==========================================================
   // Checks
   a_shift_stops: assert property (
      @(posedge fifo_read_clock) disable iff (fifo_read_select_n)
      (f_r.loaded && f_r.cnt == limit && k_r.rst_sync[1])
      |=> (f_r.dout == 4'h0))
      else $error("shifter ran past word end");

endmodule // spi_readout_link

// ---- dv/host_link_model.sv ----
`timescale 1ns/1ps
module host_link_model (
   // Link pins driven by the host
   output logic fifo_read_clock,
   output logic fifo_read_select_n,
   // Lanes from the device
   input wire logic [3:0] spi_data_out
);
   initial begin
      fifo_read_clock = 1'b0;
      fifo_read_select_n = 1'b1;
   end

   // Short edges so the link sees reset
   task automatic idle_edges(input int n);
      repeat (n) begin
         #2;
         fifo_read_clock = 1'b1;
         #2;
         fifo_read_clock = 1'b0;
      end
   endtask

   task automatic frame(input int n, input bit four, output logic [19:0] w);
      w = '0;
      #3;
      fifo_read_select_n = 1'b0;
      #16;
      repeat (n) begin
         fifo_read_clock = 1'b1;
         #16;
         fifo_read_clock = 1'b0;
         // Data settled since the rising edge
         w = four ? {w[15:0], spi_data_out} : {w[18:0], spi_data_out[0]};
         #16;
      end
      // Clock stands still while deselected
      fifo_read_select_n = 1'b1;
      #16;
   endtask
endmodule // host_link_model

// ---- dv/adc_status_readout_tb.sv ----
`timescale 1ns/1ps
module adc_status_readout_tb;
   logic clk_sys = 1'b0;
   logic reset_n;
   logic clk_en;
   adc_cfg_pkg::reg_req_t reg_req;
   logic [7:0] reg_rdata;
   adc_cfg_pkg::events_t events;
   logic [19:0] conv_word;
   logic conv_valid;
   logic [19:0] lvds_word;
   logic lvds_word_valid;
   logic lvds_power_down;
   logic [2:0] active_lanes;
   logic fifo_read_clock;
   logic fifo_read_select_n;
   logic [3:0] spi_data_out;
   logic [19:0] w;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   logic [5:0] ev_tab [4] = '{6'h20, 6'h02, 6'h10, 6'h08};
   logic [7:0] flag_tab [4] = '{8'h10, 8'h04, 8'h08, 8'h01};
   localparam logic [7:0] ST = adc_cfg_pkg::STATUS_ADDR;
   localparam logic [7:0] CF = adc_cfg_pkg::CFG_ADDR;

   always #2 clk_sys = ~clk_sys;

   adc_status_readout u_adc_status_readout (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .events(events),
      .conv_word(conv_word), .conv_valid(conv_valid),
      .lvds_word(lvds_word), .lvds_word_valid(lvds_word_valid),
      .lvds_power_down(lvds_power_down), .active_lanes(active_lanes),
      .fifo_read_clock(fifo_read_clock),
      .fifo_read_select_n(fifo_read_select_n),
      .spi_data_out(spi_data_out));

   host_link_model u_host_link_model (
      .fifo_read_clock(fifo_read_clock),
      .fifo_read_select_n(fifo_read_select_n),
      .spi_data_out(spi_data_out));

   // ==========================================================
   // Checking and closing
   task automatic chk(input string name, input logic [19:0] seen,
                      input logic [19:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ==========================================================
   // Register port and stimulus tasks
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= {1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      reg_req <= '0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      reg_req <= '0;
      #1;
      chk("reg_rdata", {12'h000, reg_rdata}, {12'h000, exp});
   endtask

   task automatic ev(input logic [5:0] e);
      @(posedge clk_sys);
      events <= e;
      @(posedge clk_sys);
      events <= '0;
   endtask

   task automatic conv(input logic [19:0] d);
      @(posedge clk_sys);
      conv_word <= d;
      conv_valid <= 1'b1;
      @(posedge clk_sys);
      conv_valid <= 1'b0;
      #1;
   endtask

   task automatic settle_cfg(input logic pd, input logic [2:0] lanes);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("lvds_power_down", {19'h0, lvds_power_down}, {19'h0, pd});
      chk("active_lanes", {17'h0, active_lanes}, {17'h0, lanes});
   endtask

   // ==========================================================
   // Tests
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      reg_req = '0;
      events = '0;
      conv_word = '0;
      conv_valid = 1'b0;
      u_host_link_model.idle_edges(4);
      @(posedge clk_sys);
      reset_n <= 1'b1;

      reg_rd(ST, 8'h09);
      reg_rd(CF, 8'h40);
      reg_rd(8'h20, 8'h00);
      reg_wr(ST, 8'h00);
      reg_rd(ST, 8'h09);
      reg_wr(ST, 8'h09);
      reg_rd(ST, 8'h00);
      $display("test reset_values done");

      for (int i = 0; i < 4; i++) begin
         ev(ev_tab[i]);
         reg_rd(ST, flag_tab[i]);
         reg_wr(ST, flag_tab[i]);
         reg_rd(ST, 8'h00);
      end
      @(posedge clk_sys);
      events <= 6'h20;
      reg_req <= {1'b1, 1'b0, ST, 8'h10};
      @(posedge clk_sys);
      events <= '0;
      reg_req <= '0;
      reg_rd(ST, 8'h10);
      reg_wr(ST, 8'h10);
      ev(6'h01);
      reg_wr(ST, 8'h1f);
      reg_rd(ST, 8'h02);
      $display("test status_flags done");

      // Reserved bits written as zero, as the host must
      reg_wr(CF, 8'h55);
      reg_rd(CF, 8'h55);
      reg_wr(CF, 8'h40);
      settle_cfg(1'b0, 3'h1);
      conv(20'h12345);
      chk("lvds_word_valid", {19'h0, lvds_word_valid}, 20'h1);
      chk("lvds_word", lvds_word, 20'h12345);
      reg_wr(CF, 8'h54);
      settle_cfg(1'b0, 3'h2);
      conv(20'h11111);
      chk("lvds_word", lvds_word, adc_cfg_pkg::TEST_PATTERN);
      $display("test lvds_path done");

      reg_wr(CF, 8'h51);
      settle_cfg(1'b1, 3'h1);
      conv(20'h3c5a9);
      repeat (4) @(posedge clk_sys);
      // First frame only brings the handoff across
      u_host_link_model.frame(2, 1'b0, w);
      u_host_link_model.frame(20, 1'b0, w);
      chk("spi_one_lane", w, 20'h3c5a9);
      reg_wr(CF, 8'h45);
      settle_cfg(1'b1, 3'h4);
      conv(20'h96e1b);
      repeat (4) @(posedge clk_sys);
      u_host_link_model.frame(2, 1'b1, w);
      u_host_link_model.frame(5, 1'b1, w);
      chk("spi_four_lane", w, 20'h96e1b);
      $display("test spi_path done");

      // Enable low: an event must not reach the flags
      @(posedge clk_sys);
      clk_en <= 1'b0;
      ev(6'h20);
      clk_en <= 1'b1;
      reg_rd(ST, 8'h02);
      $display("test clock_enable done");

      ev(6'h04);
      reg_rd(ST, 8'h0b);
      reg_rd(CF, 8'h40);
      $display("test soft_reset done");
      complete_run();
   end
endmodule // adc_status_readout_tb
